/* File: design/bse_consts.vh */
// constants for the bit string expander: register offsets, fields, limits
// assumes inclusion by the design files only; holds definitions only
`ifndef BSE_CONSTS_VH
`define BSE_CONSTS_VH

// register byte offsets on the AHB-Lite slave
`define BSE_OFF_BASE 8'h00
`define BSE_OFF_OFFSET 8'h04
`define BSE_OFF_COUNT 8'h08
`define BSE_OFF_TABWARP 8'h0C
`define BSE_OFF_CTRL 8'h10
`define BSE_OFF_STATUS 8'h14

// control register command bits (write one to start)
`define BSE_CTRL_CONTIG 0
`define BSE_CTRL_STEP 1

// status register bits
`define BSE_STAT_BUSY 0
`define BSE_STAT_TOOLONG 1

// longest run the contiguous instruction handles itself
`define BSE_CONTIG_MAX 32'h00000019
// size of the external lookup table in bytes
`define BSE_TABLE_BYTES 1024

// register reset values
`define BSE_RST_WORD 32'h00000000

`endif

/* File: design/bse_addr_calc.v */
// bit address former: byte base plus signed bit offset
// assumes base is a byte address and offset counts bits from bit 0
`timescale 1ns/1ns
`default_nettype none
module bse_addr_calc (
	input wire [31:0] baseAddr,
	input wire [31:0] bitOffset,
	output wire [31:0] byteAddr,
	output wire [2:0] bitPos
);
	wire [34:0] baseBits;
	wire [34:0] offExt;
	wire [34:0] bitAddr;

	// eight bits per byte, offset sign-extended so negatives step down
	assign baseBits = {baseAddr, 3'b000}; // RQ11
	assign offExt = {{3{bitOffset[31]}}, bitOffset}; // RQ2
	assign bitAddr = baseBits + offExt; // RQ11
	assign byteAddr = bitAddr[34:3];
	assign bitPos = bitAddr[2:0];
endmodule
`default_nettype wire

/* File: design/bse_expander.v */
// bit string expander: contiguous and stepped runs of ones into memory
// assumes an AHB-Lite master with single word transfers and a byte-wide
// external memory that answers each request with a one-cycle memAck
// and software that waits for busy low before new setup words
//
// How it works
// (RQ1) contiguous run writes count ones from base+offset
// (RQ2) contiguous offset signed, count unsigned
// (RQ3) count up to 25: clear flag, write bits
// (RQ4) count above 25: set flag, no memory access
// (RQ5) patterns fetched from 1k byte table
// (RQ6) contiguous run leaves all four registers unchanged
// (RQ7) stepped run sets bit, adds warp, repeats
// (RQ8) warp is a signed distance in bits
// (RQ9) stepped run: offset final, count zero, others kept
// (RQ10) warp of one gives a horizontal run
// (RQ11) bit address is 8*base plus offset, lsb first
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "bse_consts.vh"
module bse_expander (
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg memReq,
	output reg memWe,
	output reg [31:0] memAddr,
	output reg [7:0] memWdata,
	input wire [7:0] memRdata,
	input wire memAck,
	output reg busy
);
	// one-hot states
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_TABLE = 4'h2;
	localparam [3:0] ST_READ = 4'h4;
	localparam [3:0] ST_WRITE = 4'h8;

	// software-visible setup words and the too-long flag
	reg [31:0] base_reg;
	reg [31:0] offset_reg;
	reg [31:0] count_reg;
	reg [31:0] tabWarp_reg;
	reg tooLong_reg;
	// run engine; workOff and workCnt walk a contiguous run
	reg [3:0] state_reg;
	reg modeStep_reg;
	reg [31:0] workOff_reg;
	reg [4:0] workCnt_reg;
	reg [7:0] mask_reg;
	reg [3:0] used_reg;
	// bus write seen in the address phase, applied in the data phase
	reg wrPend_reg;
	reg [7:0] wrAddr_reg;

	wire [31:0] curOff;
	wire [31:0] curByte;
	wire [2:0] curBit;
	wire [3:0] room;
	wire [3:0] take;
	wire [9:0] tabIndex;
	wire busStart;
	wire regWrite;
	wire [31:0] stepOff;
	// register strobes and next values of the walking registers
	wire wrBase;
	wire wrOffset;
	wire wrCount;
	wire wrTabWarp;
	wire wrCtrl;
	wire startContig;
	wire startStep;
	wire [31:0] workOff_next;
	wire [4:0] workCnt_next;
	wire [31:0] count_next;
	wire stepLast;
	wire contigLast;

	// choose the live offset: stepped mode walks the register itself
	assign curOff = modeStep_reg ? offset_reg : workOff_reg;

	// one shared address former for both run kinds
	bse_addr_calc addrCalc (
		.baseAddr(base_reg),
		.bitOffset(curOff),
		.byteAddr(curByte),
		.bitPos(curBit)
	);

	// bits this byte can still take, then capped by what is left
	assign room = 4'h8 - {1'b0, curBit};
	assign take = ({1'b0, workCnt_reg} < {1'b0, room}) ?
		workCnt_reg[3:0] : room;
	// table indexed by start bit and remaining length
	assign tabIndex = {curBit, 2'b00, workCnt_reg}; // RQ5
	// signed warp add, wraps like the offset register does
	assign stepOff = offset_reg + tabWarp_reg; // RQ8

	// next values once a bit or piece has been written back
	assign workOff_next = workOff_reg + {28'h0000000, used_reg}; // RQ1
	assign workCnt_next = workCnt_reg - {1'b0, used_reg};
	assign count_next = count_reg - 32'h00000001; // RQ9
	// run ends on the write of its last bit or last piece
	assign stepLast = (count_reg == 32'h00000001);
	assign contigLast = (workCnt_reg == {1'b0, used_reg});

	// address phase accepted when selected and a transfer is requested
	assign busStart = hsel & htrans[1] & hready;
	assign regWrite = wrPend_reg;

	// register select decode, shared by every write strobe
	function regHit;
		input pend;
		input [7:0] addr;
		input [7:0] off;
		begin
			regHit = pend & (addr == off);
		end
	endfunction

	// one strobe per setup word, from the captured address
	assign wrBase = regHit(regWrite, wrAddr_reg, `BSE_OFF_BASE);
	assign wrOffset = regHit(regWrite, wrAddr_reg, `BSE_OFF_OFFSET);
	assign wrCount = regHit(regWrite, wrAddr_reg, `BSE_OFF_COUNT);
	assign wrTabWarp = regHit(regWrite, wrAddr_reg, `BSE_OFF_TABWARP);
	assign wrCtrl = regHit(regWrite, wrAddr_reg, `BSE_OFF_CTRL);
	// bit0 wins when software sets both command bits
	assign startContig = wrCtrl & hwdata[`BSE_CTRL_CONTIG];
	assign startStep = wrCtrl & ~hwdata[`BSE_CTRL_CONTIG] &
		hwdata[`BSE_CTRL_STEP];

	// read mux for the register file
	function [31:0] readMux;
		input [7:0] off;
		begin
			case (off)
				`BSE_OFF_BASE: readMux = base_reg;
				`BSE_OFF_OFFSET: readMux = offset_reg;
				`BSE_OFF_COUNT: readMux = count_reg;
				`BSE_OFF_TABWARP: readMux = tabWarp_reg;
				`BSE_OFF_STATUS: readMux = {30'h00000000, tooLong_reg, busy};
				default: readMux = `BSE_RST_WORD;
			endcase
		end
	endfunction

	// bus slave: zero wait states, read data registered at address phase
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= `BSE_RST_WORD;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// write lands one cycle later, at the end of the data phase
			wrPend_reg <= busStart & hwrite;
			if (busStart) begin
				wrAddr_reg <= haddr[7:0];
			end
			if (busStart & ~hwrite & (haddr[31:8] == 24'h000000)) begin
				hrdata <= readMux(haddr[7:0]);
			end else if (busStart) begin
				hrdata <= `BSE_RST_WORD;
			end
		end
	end

	// setup registers, flag and the run engine in one process
	// register writes while busy are dropped so a run cannot be corrupted
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			base_reg <= `BSE_RST_WORD;
			offset_reg <= `BSE_RST_WORD;
			count_reg <= `BSE_RST_WORD;
			tabWarp_reg <= `BSE_RST_WORD;
			tooLong_reg <= 1'b0;
			state_reg <= ST_IDLE;
			modeStep_reg <= 1'b0;
			workOff_reg <= `BSE_RST_WORD;
			workCnt_reg <= 5'h00;
			mask_reg <= 8'h00;
			used_reg <= 4'h0;
			memReq <= 1'b0;
			memWe <= 1'b0;
			memAddr <= `BSE_RST_WORD;
			memWdata <= 8'h00;
			busy <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// software writes to the setup words only land between runs
					if (wrBase)
						base_reg <= hwdata;
					if (wrOffset)
						offset_reg <= hwdata;
					if (wrCount)
						count_reg <= hwdata;
					if (wrTabWarp)
						tabWarp_reg <= hwdata;
					// length checked before any memory access
					if (startContig) begin
						modeStep_reg <= 1'b0;
						workOff_reg <= offset_reg; // RQ6
						if (count_reg > `BSE_CONTIG_MAX) begin
							tooLong_reg <= 1'b1; // RQ4
						end else begin
							tooLong_reg <= 1'b0; // RQ3
							workCnt_reg <= count_reg[4:0]; // RQ2
							if (count_reg != `BSE_RST_WORD) begin
								state_reg <= ST_TABLE; // RQ1
								busy <= 1'b1;
							end
						end
					end else if (startStep) begin
						modeStep_reg <= 1'b1;
						if (count_reg != `BSE_RST_WORD) begin
							state_reg <= ST_READ; // RQ7
							busy <= 1'b1;
						end
					end
				end
				ST_TABLE: begin
					// fetch the byte pattern for this piece of the run
					if (!memReq) begin
						memReq <= 1'b1;
						memWe <= 1'b0;
						memAddr <= tabWarp_reg + {22'h000000, tabIndex}; // RQ5
						used_reg <= take;
					end else if (memAck) begin
						memReq <= 1'b0;
						mask_reg <= memRdata; // RQ5
						state_reg <= ST_READ;
					end
				end
				ST_READ: begin
					// read-modify-write keeps the other bits of the byte
					if (!memReq) begin
						memReq <= 1'b1;
						memWe <= 1'b0;
						memAddr <= curByte;
						// stepped mode sets one bit per access
						if (modeStep_reg)
							mask_reg <= 8'h01 << curBit; // RQ11
					end else if (memAck) begin
						memReq <= 1'b0;
						memWdata <= memRdata | mask_reg; // RQ11
						state_reg <= ST_WRITE;
					end
				end
				// write back, then advance to the next bit or piece
				ST_WRITE: begin
					if (!memReq) begin
						memReq <= 1'b1;
						memWe <= 1'b1;
					end else if (memAck) begin
						memReq <= 1'b0;
						memWe <= 1'b0;
						if (modeStep_reg) begin
							// warp applied after each bit, like a pointer
							offset_reg <= stepOff; // RQ10
							count_reg <= count_next; // RQ9
							if (stepLast) begin
								state_reg <= ST_IDLE;
								busy <= 1'b0;
							end else begin
								state_reg <= ST_READ; // RQ7
							end
						end else begin
							// a piece never crosses a byte boundary
							workOff_reg <= workOff_next; // RQ1
							workCnt_reg <= workCnt_next;
							if (contigLast) begin
								state_reg <= ST_IDLE;
								busy <= 1'b0;
							end else begin
								state_reg <= ST_TABLE;
							end
						end
					end
				end
				default: begin
					// stray one-hot code: drop any request, go idle
					state_reg <= ST_IDLE;
					busy <= 1'b0;
					memReq <= 1'b0;
					memWe <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: tb/bse_monitor.sv */
// checker: bus and memory-side timing of the expander
// assumes one clock domain and writes of whole words
`timescale 1ns/1ns
`default_nettype none
module bse_monitor (
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hwdata,
	input wire memReq,
	input wire memWe,
	input wire [31:0] memAddr,
	input wire memAck,
	input wire busy
);
	reg wrReg;
	reg [7:0] adReg;
	reg [31:0] bReg, oReg, cReg, tReg;
	wire go = wrReg && adReg == 8'h10 && !busy;
	wire goC = go && hwdata[0];
	wire goS = go && hwdata[1:0] == 2'h2;
	wire [31:0] first = bReg + {{3{oReg[31]}}, oReg[31:3]};
	// shadow of setup words; writes while busy are refused, so skip them
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{wrReg, adReg, bReg, oReg, cReg, tReg} <= 137'h0;
		end else begin
			wrReg <= hsel && htrans[1] && hready && hwrite;
			adReg <= haddr[7:0];
			if (wrReg && !busy) begin
				case (adReg)
					8'h00: bReg <= hwdata;
					8'h04: oReg <= hwdata;
					8'h08: cReg <= hwdata;
					8'h0C: tReg <= hwdata;
					default: ;
				endcase
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_drop; memReq && memAck |=> !memReq; endproperty
	a_drop: assert property (p_drop) else $error("request held");
	property p_idle; !busy |-> !memReq; endproperty
	a_idle: assert property (p_idle) else $error("access when idle");
	property p_long; goC && cReg > 32'h19 |=> !busy [*3]; endproperty
	a_long: assert property (p_long) else $error("long run started");
	property p_skip; goC && cReg == 32'h0 |=> !memReq [*4]; endproperty
	a_skip: assert property (p_skip) else $error("empty run access");
	property p_tab; goC && cReg != 32'h0 && cReg < 32'h1A |->
		##[1:4] (memReq && !memWe && memAddr - tReg < 32'h400); endproperty
	a_tab: assert property (p_tab) else $error("no table read");
	property p_first; goS && cReg != 32'h0 |->
		##[1:4] (memReq && memAddr == first); endproperty
	a_first: assert property (p_first) else $error("bad first byte");
	property p_none; goS && cReg == 32'h0 |=> !memReq [*4]; endproperty
	a_none: assert property (p_none) else $error("empty step access");
	c_long: cover property (goC && cReg > 32'h19);
	c_step: cover property (goS && cReg != 32'h0);
	c_wr: cover property (memReq && memWe && memAck);
endmodule
bind bse_expander bse_monitor mon_u (.mclk(mclk), .arst_n(arst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hwdata(hwdata), .memReq(memReq), .memWe(memWe),
	.memAddr(memAddr), .memAck(memAck), .busy(busy));
`default_nettype wire

/* File: tb/bse_mem_model.sv */
// byte memory holding bitmap and lookup table
// assumes requests held until memAck; bench preloads the array
`timescale 1ns/1ns
`default_nettype none
module bse_mem_model (
	input wire mclk,
	input wire arst_n,
	input wire memReq,
	input wire memWe,
	input wire [31:0] memAddr,
	input wire [7:0] memWdata,
	input wire [3:0] slow,
	output logic [7:0] memRdata,
	output logic memAck
);
	logic [7:0] mem [0:4095];
	logic [3:0] waitReg;
	// answer after slow idle cycles; read data toggles except on a read answer
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			memAck <= 1'h0;
			waitReg <= 4'h0;
			memRdata <= 8'hA5;
		end else begin
			memAck <= 1'h0;
			memRdata <= ~memRdata;
			if (memReq && !memAck && waitReg == slow) begin
				memAck <= 1'h1;
				waitReg <= 4'h0;
				if (memWe)
					mem[memAddr[11:0]] <= memWdata;
				else
					memRdata <= mem[memAddr[11:0]];
			end else if (memReq && !memAck)
				waitReg <= waitReg + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/bse_expander_tb.sv */
// bench: runs through the AHB-Lite registers, memory compared after each
// assumes zero-wait bus slave and bitmap base at byte 0x100
`timescale 1ns/1ns
`default_nettype none
module bse_expander_tb;
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic hwrite = 1'h0;
	logic flg = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [3:0] slow = 4'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, ba, fo, fc;
	logic [7:0] wantMem [0:4095];
	wire [31:0] hrdata, memAddr;
	wire [7:0] memWdata, memRdata;
	wire hreadyout, hresp, memReq, memWe, memAck, busy;
	int mismatches = 0, checks_done = 0, i, p, k;
	always #5 mclk = ~mclk;
	bse_expander dut_u (.mclk(mclk), .arst_n(arst_n), .hsel(1'h1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .memAck(memAck), .busy(busy));
	bse_mem_model mem_u (.mclk(mclk), .arst_n(arst_n), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.slow(slow), .memRdata(memRdata), .memAck(memAck));
	task chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			mismatches++;
			$display("FAIL %0t got %h want %h", $time, got, want);
		end
	endtask
	// one single transfer; an idle cycle always precedes the next
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'h1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task run(input logic st, input logic [31:0] o, c, w);
		fo = st && c != 32'h0 ? o + c * w : o;
		fc = st ? 32'h0 : c;
		if (!st)
			flg = c > 32'h19;
		for (i = 0; i < c && (st || !flg); i++) begin
			ba = 32'h800 + o + (st ? i * w : i);
			wantMem[ba[14:3]][ba[2:0]] = 1'h1;
		end
		xfer(1'h1, 8'h00, 32'h100);
		xfer(1'h1, 8'h04, o);
		xfer(1'h1, 8'h08, c);
		xfer(1'h1, 8'h0C, w);
		xfer(1'h1, 8'h10, st ? 32'h2 : 32'h1);
		for (i = 0; i < 300 && (i == 0 || rd[0] !== 1'h0); i++)
			xfer(1'h0, 8'h14, 32'h0);
		chk({29'h0, busy, rd[1:0]}, {30'h0, flg, 1'h0});
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, fo);
		xfer(1'h0, 8'h08, 32'h0);
		chk(rd, fc);
		xfer(1'h0, 8'h0C, 32'h0);
		chk(rd, w);
		xfer(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h100);
		for (i = 0; i < 4096; i++)
			chk({24'h0, mem_u.mem[i]}, {24'h0, wantMem[i]});
		$display("test done offset %0d count %0d", $signed(o), c);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// table at 0x400 holds the plain run mask for bit position and length
	initial begin
		for (i = 0; i < 4096; i++) begin
			p = (i >> 7) & 7;
			k = (i & 31) < 8 - p ? i & 31 : 8 - p;
			wantMem[i] = i >= 32'h400 && i < 32'h800 ? (8'hFF >> (8 - k)) << p : 8'h0;
			mem_u.mem[i] = wantMem[i];
		end
		repeat (20) @(posedge mclk);
		arst_n <= 1'h1;
		xfer(1'h0, 8'h18, 32'h0);
		chk(rd, 32'h0);
		run(1'h0, 32'h5, 32'h19, 32'h400);
		run(1'h0, 32'hFFFFFFFD, 32'h7, 32'h400);
		run(1'h0, 32'h40, 32'h1A, 32'h400);
		run(1'h1, 32'h80, 32'h4, 32'h1);
		slow <= 4'h3;
		run(1'h1, 32'hC2, 32'h3, 32'hFFFFFFF7);
		run(1'h1, 32'h200, 32'h3, 32'hFFFFFFFF);
		run(1'h0, 32'h300, 32'h0, 32'h400);
		report_and_stop;
	end
	// watchdog well past the expected run length
	initial begin
		#500000;
		$display("FAIL %0t watchdog expired", $time);
		mismatches++;
		report_and_stop;
	end
endmodule
`default_nettype wire
